/* ars_axil_slave.sv */
// axi4-lite slave register front end
`timescale 1ns/1ps
module ars_axil_slave (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // write channels
    input wire logic [11:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // read channels
    input wire logic [11:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // register side
    output logic wr_en,
    output logic [11:0] wr_addr,
    output logic [31:0] wr_data,
    output logic [3:0] wr_strb,
    output logic [11:0] rd_addr,
    input wire logic [31:0] rd_data,
    input wire logic rd_ok,
    input wire logic wr_ok
);
    logic aw_have_q, w_have_q;
    logic [11:0] aw_q;
    logic [31:0] w_q;
    logic [3:0] s_q;
    wire logic do_wr = aw_have_q && w_have_q && !bvalid;
    assign awready = !aw_have_q && !bvalid;
    assign wready = !w_have_q && !bvalid;
    assign arready = !rvalid;
    assign wr_en = do_wr;
    assign wr_addr = aw_q;
    assign wr_data = w_q;
    assign wr_strb = s_q;
    assign rd_addr = araddr;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            aw_q <= 12'h000;
            w_q <= 32'h00000000;
            s_q <= 4'h0;
            bvalid <= 1'b0;
            bresp <= 2'h0;
            rvalid <= 1'b0;
            rdata <= 32'h00000000;
            rresp <= 2'h0;
        end else begin
            if (awvalid && awready) begin
                aw_have_q <= 1'b1;
                aw_q <= awaddr;
            end
            if (wvalid && wready) begin
                w_have_q <= 1'b1;
                w_q <= wdata;
                s_q <= wstrb;
            end
            if (do_wr) begin
                aw_have_q <= 1'b0;
                w_have_q <= 1'b0;
                bvalid <= 1'b1;
                bresp <= wr_ok ? 2'h0 : 2'h2;
            end else if (bvalid && bready) begin
                bvalid <= 1'b0;
            end
            if (arvalid && arready) begin
                rvalid <= 1'b1;
                rdata <= rd_ok ? rd_data : 32'h00000000;
                rresp <= rd_ok ? 2'h0 : 2'h2;
            end else if (rvalid && rready) begin
                rvalid <= 1'b0;
            end
        end
    end
endmodule

/* ars_consts.svh */
// constants for the analyzer readout sequencing block
// Summary of operation
// - transfer command copies output register to latch
// - latch empty flag when all latch bits zero
// - analog readout cycles repeat while latch empty
// - empty channel forces latch to one
// - decade lines hold output zero, latch one
// - phase flip-flop drives complementary phase flags
// - analog phase one plots points, two decades
// - digital phase two returns carriage, dummy read
// - channel step advances counter by one
// - jump by sixteen only during decade lines
// - add needs tally set and add position
// - converter reject clears tally flip-flop
// - converter store starts storage memory cycle
// - digit step moves digit counter forward/backward
// - tally set alters next digit plus/minus one
// - wrap pulse at range top, not reset
// - auto-repeat needs switch on and digital mode
// - timed halt clears analyze flip-flop when qualified
// - group first channel flag on group start
// - stage gates depend on selected range
// - stage8 decoder input follows overlap switch
// - flag least significant digit of channel seven
// - adder wraps nine/zero and requests repeat
// - range top select inverted stage per range
`ifndef ARS_CONSTS_SVH
`define ARS_CONSTS_SVH
`define ARS_CHAN_W 9
`define ARS_DIGIT_W 4
`define ARS_DPOS_W 3
`define ARS_JUMP_STEP 9'h010
`define ARS_LATCH_ONE 4'h1
`define ARS_DIGIT_NINE 4'h9
`define ARS_CH7 9'h007
`define ARS_DPOS_LSD 3'h0
`define ARS_RANGE_128 2'h0
`define ARS_RANGE_256 2'h1
`define ARS_RANGE_512 2'h2
// register offsets
`define ARS_REG_CTRL 12'h000
`define ARS_REG_MODE 12'h004
`define ARS_REG_CMD 12'h008
`define ARS_REG_STAT 12'h00C
`define ARS_REG_ADDR 12'h010
`define ARS_REG_DIG 12'h014
// control bits
`define ARS_CTRL_READ 0
`define ARS_CTRL_ANALOG 1
`define ARS_CTRL_ADD 2
`define ARS_CTRL_AUTOREP 3
`define ARS_CTRL_OVERLAP 4
`define ARS_CTRL_DLINE 5
`define ARS_CTRL_RANGE 6
// command bits (write one pulses)
`define ARS_CMD_STEP 0
`define ARS_CMD_JUMP16 1
`define ARS_CMD_DSTEP 2
`define ARS_CMD_FWD 3
`define ARS_CMD_COPY 4
`define ARS_CMD_PHSET 5
`define ARS_CMD_PHCLR 6
`define ARS_CMD_TALLY 7
`define ARS_CMD_CHRST 8
`define ARS_CMD_INTERR 9
`define ARS_CMD_ANALYZE 10
`define ARS_CMD_LOADGRP 11
`endif

/* ars_conv_model.sv */
// converter and memory array stand-in
`timescale 1ns/1ps
module ars_conv_model (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // bench commands
    input wire logic do_store,
    input wire logic do_reject,
    input wire logic [3:0] digit,
    input wire logic [2:0] digit_pos,
    // device side
    output logic converter_store_request,
    output logic converter_reject_pulse,
    output logic [3:0] mem_digit_in
);
    always_ff @(posedge aclk) begin
        converter_store_request <= aresetn & do_store;
        converter_reject_pulse <= aresetn & do_reject;
    end
    // only the low digit holds data, higher digits read zero
    assign mem_digit_in = digit_pos == 3'h0 ? digit : 4'h0;
endmodule

/* ars_digit_adder.sv */
// decimal digit adder with wrap and repeat request
`timescale 1ns/1ps
`include "ars_consts.svh"
module ars_digit_adder (
    // operands
    input wire logic [3:0] digit_in,
    input wire logic add_cmd,
    input wire logic sub_cmd,
    // results
    output logic [3:0] digit_out,
    output logic repeat_req
);
    wire logic is_nine = (digit_in == `ARS_DIGIT_NINE);
    wire logic is_zero = (digit_in == 4'h0);
    assign repeat_req = (add_cmd && is_nine) || (sub_cmd && is_zero);
    assign digit_out = add_cmd ? (is_nine ? 4'h0 : digit_in + 4'h1) :
                       sub_cmd ? (is_zero ? `ARS_DIGIT_NINE : digit_in - 4'h1) : digit_in;
endmodule

/* ars_pkg.sv */
// types for the analyzer readout sequencing block
package ars_pkg;
    typedef enum logic [1:0] {ARS_R128, ARS_R256, ARS_R512, ARS_RRES} ars_range_t;
    typedef enum {ARS_IDLE, ARS_READ, ARS_WRITE, ARS_CHECK} ars_mem_state_t;
endpackage

/* ars_readout_chk.sv */
// port assertions for the readout sequencing block
`timescale 1ns/1ps
module ars_readout_chk #(
    parameter int CHAN_W = 9
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // inputs
    input wire logic converter_store_request,
    // outputs
    input wire logic mem_cycle_busy,
    input wire logic [3:0] held_digit_latch,
    input wire logic held_latch_empty,
    input wire logic phase_one_flag,
    input wire logic phase_two_flag,
    input wire logic channel_wrap_pulse,
    input wire logic channel7_low_digit_flag,
    input wire logic [CHAN_W-1:0] channel_addr,
    input wire logic [2:0] digit_pos
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    property p_empty;
        held_latch_empty == (held_digit_latch == 4'h0);
    endproperty
    a_empty: assert property (p_empty) else $error("latch empty flag wrong");
    property p_phase;
        phase_one_flag != phase_two_flag;
    endproperty
    a_phase: assert property (p_phase) else $error("phase flags not complementary");
    property p_rst;
        disable iff (1'b0) !aresetn |=> channel_addr == '0 && digit_pos == 3'h0
            && held_digit_latch == 4'h0 && phase_one_flag;
    endproperty
    a_rst: assert property (p_rst) else $error("reset state wrong");
    property p_wrap_addr;
        channel_wrap_pulse |-> channel_addr == '0;
    endproperty
    a_wrap_addr: assert property (p_wrap_addr) else $error("wrap away from zero");
    property p_wrap_one;
        channel_wrap_pulse |=> !channel_wrap_pulse;
    endproperty
    a_wrap_one: assert property (p_wrap_one) else $error("wrap pulse too long");
    property p_ch7;
        channel7_low_digit_flag == (channel_addr == CHAN_W'(7) && digit_pos == 3'h0);
    endproperty
    a_ch7: assert property (p_ch7) else $error("channel seven flag wrong");
    property p_store;
        converter_store_request && !mem_cycle_busy |=> mem_cycle_busy [*3];
    endproperty
    a_store: assert property (p_store) else $error("store gave no cycle");
    property p_dstep;
        $changed(digit_pos) |-> 3'(digit_pos - $past(digit_pos)) inside {3'h1, 3'h7};
    endproperty
    a_dstep: assert property (p_dstep) else $error("digit step not one");
endmodule

/* ars_readout_top.sv */
// readout sequencing core with register map
//
// The register offsets and the AXI4-Lite slave port are this design's own decisions.
`timescale 1ns/1ps
`include "ars_consts.svh"
module ars_readout_top #(
    parameter int CHAN_W = `ARS_CHAN_W
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write
    input wire logic [11:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // axi4-lite read
    input wire logic [11:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // converter
    input wire logic converter_store_request,
    input wire logic converter_reject_pulse,
    // panel qualifiers
    input wire logic time_conditions_met,
    input wire logic halt_qualify,
    // memory array
    input wire logic [3:0] mem_digit_in,
    output logic [3:0] mem_digit_out,
    output logic mem_cycle_busy,
    // status outputs
    output logic [3:0] held_digit_latch,
    output logic held_latch_empty,
    output logic phase_one_flag,
    output logic phase_two_flag,
    output logic channel_wrap_pulse,
    output logic carriage_return_pulse,
    output logic point_plot_strobe,
    output logic repeat_readout_enable,
    output logic timed_halt_signal,
    output logic group_first_channel,
    output logic channel7_low_digit_flag,
    output logic [CHAN_W-1:0] channel_addr,
    output logic [2:0] digit_pos
);
    import ars_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // bus front end
    logic wr_en, rd_ok, wr_ok;
    logic [11:0] wr_addr, rd_addr;
    logic [31:0] wr_data, rd_data;
    logic [3:0] wr_strb;
    ars_axil_slave u_bus (
        .aclk(aclk),
        .aresetn(aresetn),
        .awaddr(awaddr),
        .awvalid(awvalid),
        .awready(awready),
        .wdata(wdata),
        .wstrb(wstrb),
        .wvalid(wvalid),
        .wready(wready),
        .bresp(bresp),
        .bvalid(bvalid),
        .bready(bready),
        .araddr(araddr),
        .arvalid(arvalid),
        .arready(arready),
        .rdata(rdata),
        .rresp(rresp),
        .rvalid(rvalid),
        .rready(rready),
        .wr_en(wr_en),
        .wr_addr(wr_addr),
        .wr_data(wr_data),
        .wr_strb(wr_strb),
        .rd_addr(rd_addr),
        .rd_data(rd_data),
        .rd_ok(rd_ok),
        .wr_ok(wr_ok)
    );

    ////////////////////////////////////////////////////////////////////////
    // control register
    logic [7:0] ctrl_q;
    wire logic ctrl_wr = wr_en && wr_addr == `ARS_REG_CTRL && wr_strb[0];
    wire logic cmd_wr = wr_en && wr_addr == `ARS_REG_CMD;
    wire logic [15:0] cmd = cmd_wr ? wr_data[15:0] : 16'h0000;
    wire logic read_mode = ctrl_q[`ARS_CTRL_READ];
    wire logic analog_mode = ctrl_q[`ARS_CTRL_ANALOG];
    wire logic add_sel = ctrl_q[`ARS_CTRL_ADD];
    wire logic autorep_sw = ctrl_q[`ARS_CTRL_AUTOREP];
    wire logic overlap_sw = ctrl_q[`ARS_CTRL_OVERLAP];
    wire logic dline_mode = ctrl_q[`ARS_CTRL_DLINE];
    wire ars_range_t range_sel = ars_range_t'(ctrl_q[`ARS_CTRL_RANGE +: 2]);
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_q <= 8'h00;
        end else if (ctrl_wr) begin
            ctrl_q <= wr_data[7:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // phase and tally flip-flops
    logic phase_q, tally_q, analyze_q;
    assign phase_one_flag = phase_q;
    assign phase_two_flag = !phase_q;
    assign timed_halt_signal = time_conditions_met;
    wire logic halt_now = timed_halt_signal && halt_qualify;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            phase_q <= 1'b1;
            tally_q <= 1'b0;
            analyze_q <= 1'b0;
        end else begin
            if (cmd[`ARS_CMD_PHSET]) begin
                phase_q <= 1'b1;
            end else if (cmd[`ARS_CMD_PHCLR]) begin
                phase_q <= 1'b0;
            end
            if (converter_reject_pulse) begin
                tally_q <= 1'b0;
            end else if (cmd[`ARS_CMD_TALLY]) begin
                tally_q <= 1'b1;
            end
            if (halt_now) begin
                analyze_q <= 1'b0;
            end else if (cmd[`ARS_CMD_ANALYZE]) begin
                analyze_q <= 1'b1;
            end
        end
    end
    wire logic add_cmd = tally_q && add_sel;
    wire logic sub_cmd = tally_q && !add_sel;
    assign repeat_readout_enable = autorep_sw && !analog_mode;

    ////////////////////////////////////////////////////////////////////////
    // channel and digit counters
    logic [CHAN_W-1:0] chan_q;
    logic [2:0] dpos_q;
    logic wrap_q;
    logic dpos_up, dpos_dn;
    wire logic step_channel_counter = cmd[`ARS_CMD_STEP];
    wire logic jump_channel_by_sixteen = cmd[`ARS_CMD_JUMP16] && dline_mode && read_mode;
    wire logic step_digit_counter = cmd[`ARS_CMD_DSTEP];
    wire logic digit_step_forward = cmd[`ARS_CMD_FWD];
    wire logic digit_step_backward = !cmd[`ARS_CMD_FWD];
    wire logic range_top_select = (range_sel == ARS_R128) ? !chan_q[6] :
                                  (range_sel == ARS_R256) ? !chan_q[7] : !chan_q[8];
    wire logic [CHAN_W-1:0] chan_next = chan_q + CHAN_W'(1);
    wire logic at_top = (range_sel == ARS_R128) ? (chan_q[6:0] == 7'h7F) :
                        (range_sel == ARS_R256) ? (chan_q[7:0] == 8'hFF) :
                        (chan_q == 9'h1FF);
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            chan_q <= '0;
            dpos_q <= 3'h0;
            wrap_q <= 1'b0;
        end else begin
            wrap_q <= step_channel_counter && at_top && !cmd[`ARS_CMD_CHRST] && !range_top_select;
            if (cmd[`ARS_CMD_CHRST]) begin
                chan_q <= '0;
            end else if (step_channel_counter) begin
                chan_q <= at_top ? '0 : chan_next;
            end else if (jump_channel_by_sixteen) begin
                chan_q <= chan_q + CHAN_W'(`ARS_JUMP_STEP);
            end
            if ((step_digit_counter && digit_step_forward) || dpos_up) begin
                dpos_q <= dpos_q + 3'h1;
            end else if ((step_digit_counter && digit_step_backward) || dpos_dn) begin
                dpos_q <= dpos_q - 3'h1;
            end
        end
    end
    assign channel_wrap_pulse = wrap_q;
    assign channel_addr = chan_q;
    assign digit_pos = dpos_q;

    ////////////////////////////////////////////////////////////////////////
    // group decode
    // range dependent stage gates
    wire logic stage7_gate_input = (range_sel == ARS_R128) ? 1'b1 : !chan_q[7];
    wire logic stage8_gate_input = (range_sel == ARS_R512) ? !chan_q[8] : 1'b1;
    wire logic stage8_decoder_input = overlap_sw ? 1'b0 : chan_q[8];
    logic [1:0] grp_q;
    wire logic grp_match = (range_sel == ARS_R512) ? 1'b1 :
                           (range_sel == ARS_R256) ? (stage8_decoder_input == grp_q[0]) :
                           (chan_q[8:7] == grp_q);
    assign group_first_channel = (chan_q[6:0] == 7'h00) && grp_match &&
                                 stage7_gate_input && stage8_gate_input;
    assign channel7_low_digit_flag = (chan_q == `ARS_CH7) && (dpos_q == `ARS_DPOS_LSD);

    ////////////////////////////////////////////////////////////////////////
    // memory cycle sequencer
    ars_mem_state_t st_q;
    logic [3:0] out_q, latch_q, wdig_q;
    logic rep_q, interr_q, cr_q, plot_q;
    wire logic [3:0] sum;
    wire logic rep_req;
    ars_digit_adder u_add (
        .digit_in(out_q),
        .add_cmd(add_cmd && !read_mode),
        .sub_cmd(sub_cmd && !read_mode),
        .digit_out(sum),
        .repeat_req(rep_req)
    );
    assign held_latch_empty = (latch_q == 4'h0);
    wire logic copy_to_held_latch = cmd[`ARS_CMD_COPY] && st_q == ARS_IDLE;
    assign dpos_up = st_q == ARS_CHECK && rep_q;
    assign dpos_dn = st_q == ARS_CHECK && !rep_q && interr_q && out_q == 4'h0 &&
                     dpos_q != `ARS_DPOS_LSD;
    wire logic analog_read = read_mode && analog_mode;
    wire logic dummy_read = read_mode && !analog_mode && !phase_q;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_q <= ARS_IDLE;
            out_q <= 4'h0;
            latch_q <= 4'h0;
            wdig_q <= 4'h0;
            rep_q <= 1'b0;
            interr_q <= 1'b0;
            cr_q <= 1'b0;
            plot_q <= 1'b0;
        end else begin
            cr_q <= 1'b0;
            plot_q <= 1'b0;
            case (st_q)
                ARS_IDLE: begin
                    if (converter_store_request || cmd[`ARS_CMD_INTERR]) begin
                        interr_q <= cmd[`ARS_CMD_INTERR] && analog_read && phase_q;
                        cr_q <= cmd[`ARS_CMD_INTERR] && dummy_read;
                        if (cmd[`ARS_CMD_INTERR] && analog_read) begin
                            latch_q <= 4'h0;
                        end
                        st_q <= ARS_READ;
                    end
                end
                ARS_READ: begin
                    out_q <= (analog_read && !phase_q) ? 4'h0 : mem_digit_in;
                    st_q <= ARS_WRITE;
                end
                ARS_WRITE: begin
                    wdig_q <= sum;
                    rep_q <= rep_req;
                    st_q <= ARS_CHECK;
                end
                ARS_CHECK: begin
                    if (analog_read && !phase_q) begin
                        latch_q <= `ARS_LATCH_ONE;
                    end else if (interr_q && out_q != 4'h0) begin
                        latch_q <= out_q;
                    end
                    if (rep_q) begin
                        st_q <= ARS_READ;
                    end else if (dpos_dn) begin
                        st_q <= ARS_READ;
                    end else begin
                        if (interr_q && out_q == 4'h0) begin
                            latch_q <= `ARS_LATCH_ONE;
                        end
                        plot_q <= interr_q;
                        interr_q <= 1'b0;
                        st_q <= ARS_IDLE;
                    end
                end
                default: begin
                    st_q <= ARS_IDLE;
                end
            endcase
            if (copy_to_held_latch) begin
                latch_q <= out_q;
            end
        end
    end
    assign mem_digit_out = wdig_q;
    assign mem_cycle_busy = (st_q != ARS_IDLE);
    assign held_digit_latch = latch_q;
    assign carriage_return_pulse = cr_q;
    assign point_plot_strobe = plot_q;

    ////////////////////////////////////////////////////////////////////////
    // group load and readback
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            grp_q <= 2'h0;
        end else if (cmd[`ARS_CMD_LOADGRP]) begin
            grp_q <= wr_data[17:16];
        end
    end
    wire logic hit_ctrl = rd_addr == `ARS_REG_CTRL;
    wire logic hit_stat = rd_addr == `ARS_REG_STAT;
    wire logic hit_addr = rd_addr == `ARS_REG_ADDR;
    wire logic hit_dig = rd_addr == `ARS_REG_DIG;
    wire logic hit_cmd = rd_addr == `ARS_REG_CMD;
    assign rd_ok = hit_ctrl || hit_stat || hit_addr || hit_dig || hit_cmd;
    assign wr_ok = wr_addr == `ARS_REG_CTRL || wr_addr == `ARS_REG_CMD;
    wire logic [31:0] stat_word = {22'h000000, analyze_q, mem_cycle_busy, tally_q,
                                   group_first_channel, channel7_low_digit_flag,
                                   repeat_readout_enable, timed_halt_signal,
                                   phase_q, held_latch_empty, read_mode};
    assign rd_data = hit_ctrl ? {24'h000000, ctrl_q} :
                     hit_stat ? stat_word :
                     hit_addr ? {20'h00000, dpos_q, chan_q} :
                     hit_dig ? {24'h000000, latch_q, out_q} : 32'h00000000;
endmodule

/* ars_readout_top_tb.sv */
// bench for the readout sequencing block
`timescale 1ns/1ps
`include "ars_consts.svh"
module ars_readout_top_tb;
    logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0, do_store = 1'b0, do_reject = 1'b0;
    logic time_conditions_met = 1'b0, halt_qualify = 1'b0;
    logic [11:0] awaddr = 12'h000, araddr = 12'h000;
    logic [31:0] wdata = 32'h0, rdata;
    logic [3:0] digit = 4'h0, mem_digit_in, mem_digit_out, held_digit_latch;
    logic [1:0] bresp, rresp;
    logic [8:0] channel_addr;
    logic [2:0] digit_pos;
    logic awready, wready, bvalid, arready, rvalid, mem_cycle_busy, held_latch_empty;
    logic converter_store_request, converter_reject_pulse, point_plot_strobe;
    logic phase_one_flag, phase_two_flag, channel_wrap_pulse, repeat_readout_enable;
    logic timed_halt_signal, group_first_channel, channel7_low_digit_flag, carriage_return_pulse;
    int err_count = 0, checks_done = 0, wraps = 0, crs = 0, plots = 0;
    ars_conv_model u_ars_conv_model (.*);
    ars_readout_top u_ars_readout_top (.*, .wstrb(4'hF));
    initial begin
        forever #12.5 aclk = ~aclk;
    end
    always @(posedge aclk) begin
        if (channel_wrap_pulse === 1'b1) wraps++;
        if (carriage_return_pulse === 1'b1) crs++;
        if (point_plot_strobe === 1'b1) plots++;
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
        logic ta, tw, tb;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(negedge aclk);
            ta = awvalid && awready === 1'b1;
            tw = wvalid && wready === 1'b1;
            tb = bvalid === 1'b1;
            if (tb) chk("bresp", er, bresp);
            @(posedge aclk);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
        end while (!tb);
        bready <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
        logic ta, tr;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(negedge aclk);
            ta = arvalid && arready === 1'b1;
            tr = rvalid === 1'b1;
            d = rdata;
            r = rresp;
            @(posedge aclk);
            if (ta) arvalid <= 1'b0;
        end while (!tr);
        rready <= 1'b0;
    endtask
    task automatic cmd(input logic [31:0] v);
        wr(`ARS_REG_CMD, v, 2'h0);
    endtask
    task automatic ctl(input logic [31:0] v);
        wr(`ARS_REG_CTRL, v, 2'h0);
    endtask
    task automatic waitidle;
        int n, b;
        n = 0;
        b = 0;
        do begin
            @(negedge aclk);
            if (mem_cycle_busy === 1'b1) b++;
            n++;
        end while ((b == 0 || mem_cycle_busy !== 1'b0) && n < 300);
        chk("mem_cycle", 1, b > 0 && n < 300);
    endtask
    task automatic tally(input logic [31:0] c, input logic [3:0] v, input logic rej,
                         input logic [3:0] e);
        ctl(c);
        digit <= v;
        cmd(32'h80);
        @(posedge aclk);
        do_reject <= rej;
        @(posedge aclk);
        do_reject <= 1'b0;
        do_store <= 1'b1;
        @(posedge aclk);
        do_store <= 1'b0;
        waitidle();
        chk("digit_out", e, mem_digit_out);
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset;
        logic [31:0] d;
        logic [1:0] r;
        chk("phase_one", 1, phase_one_flag);
        chk("latch_empty", 1, held_latch_empty);
        rd(`ARS_REG_STAT, d, r);
        chk("stat", 32'h6, d & 32'h6);
        rd(12'h018, d, r);
        chk("unmapped", 2'h2, r);
        wr(`ARS_REG_MODE, 32'h0, 2'h2);
        cmd(32'h40);
        @(negedge aclk);
        chk("phase_two", 1, phase_two_flag);
        cmd(32'h20);
        @(negedge aclk);
        chk("phase_one", 1, phase_one_flag);
        $display("test reset done");
    endtask
    task automatic t_chan;
        repeat (7) cmd(32'h1);
        @(negedge aclk);
        chk("ch7_lsd", 1, channel7_low_digit_flag);
        cmd(32'h2);
        @(negedge aclk);
        chk("jump_off", 7, channel_addr);
        for (int r = 0; r < 3; r++) begin
            ctl(32'h21 | (r << 6));
            cmd(32'h100);
            @(negedge aclk);
            chk("grp_first", 1, group_first_channel);
            wraps = 0;
            repeat ((8 << r) - 1) cmd(32'h2);
            repeat (15) cmd(32'h1);
            @(negedge aclk);
            chk("top", (128 << r) - 1, {wraps[22:0], channel_addr});
            cmd(32'h1);
            repeat (3) @(negedge aclk);
            chk("wrap", 1, wraps);
        end
        $display("test channel done");
    endtask
    task automatic t_read;
        logic [31:0] d;
        logic [1:0] r;
        cmd(32'hC);
        cmd(32'hC);
        cmd(32'h4);
        @(negedge aclk);
        chk("dpos", 1, digit_pos);
        ctl(32'h3);
        cmd(32'h200);
        waitidle();
        chk("forced_one", 1, held_digit_latch);
        ctl(32'h1);
        digit <= 4'h5;
        cmd(32'h200);
        waitidle();
        cmd(32'h10);
        @(negedge aclk);
        chk("copy", 5, {held_latch_empty, held_digit_latch});
        cmd(32'h40);
        cmd(32'h200);
        waitidle();
        chk("carriage", 1, crs);
        ctl(32'h3);
        cmd(32'h200);
        waitidle();
        rd(`ARS_REG_DIG, d, r);
        chk("decade", 32'h10, d);
        chk("plots", 1, plots);
        $display("test readout done");
    endtask
    task automatic t_misc;
        tally(32'h4, 4'h4, 1'b0, 4'h5);
        tally(32'h0, 4'h4, 1'b0, 4'h3);
        tally(32'h4, 4'h4, 1'b1, 4'h4);
        tally(32'h4, 4'h9, 1'b0, 4'h1);
        chk("carry_pos", 1, digit_pos);
        ctl(32'h8);
        @(negedge aclk);
        chk("autorep", 1, repeat_readout_enable);
        time_conditions_met <= 1'b1;
        halt_qualify <= 1'b1;
        ctl(32'hA);
        @(negedge aclk);
        chk("autorep_an", 0, repeat_readout_enable);
        chk("halt", 1, timed_halt_signal);
        $display("test tally done");
    endtask
    task automatic complete_run;
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    initial begin
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        @(negedge aclk);
        t_reset();
        t_chan();
        t_read();
        t_misc();
        complete_run();
    end
    initial begin
        repeat (30000) @(posedge aclk);
        err_count++;
        complete_run();
    end
endmodule
bind ars_readout_top ars_readout_chk #(.CHAN_W(CHAN_W)) u_ars_readout_chk (.*);
